// File: common/pxs_pkg.sv
package pxs_pkg;
	// Sample and position widths
	localparam int ADC_W = 12;
	localparam int POS_W = 11;
	localparam logic [11:0] ADC_ALL_ONES = 12'hfff;

	// Output modes and the bit of the shifted sample that lands in output bit 0
	localparam logic [1:0] MODE_12 = 2'h0;
	localparam logic [1:0] MODE_10 = 2'h1;
	localparam logic [1:0] MODE_8 = 2'h2;
	localparam int LSB_12 = 0;
	localparam int LSB_10 = 2;
	localparam int LSB_8 = 4;

	// Sensor geometry and window reset values
	localparam logic [10:0] SENSOR_COLS = 11'h570;
	localparam logic [10:0] SENSOR_LINES = 11'h410;
	localparam logic [10:0] RST_FIRST = 11'h001;
	localparam logic [10:0] POS_ONE = 11'h001;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COLS = 8'h04;
	localparam logic [7:0] REG_LINES = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_MIN_PERIOD = 8'h10;
	localparam logic [7:0] REG_FRAMES = 8'h14;

	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SHIFT_LSB = 2;
	localparam int CTRL_VBIN_BIT = 4;
	localparam int WIN_FIRST_LSB = 0;
	localparam int WIN_COUNT_LSB = 16;
	localparam int STAT_LATE_BIT = 1;

	// Frame timing terms in units of 10 ns, then the unit size and the clock period in ns
	localparam logic [31:0] T_BASE_10NS = 32'h0000_989f;
	localparam logic [31:0] T_SKIP_10NS = 32'h0000_04be;
	localparam logic [31:0] T_LINE_10NS = 32'h0000_191d;
	localparam logic [31:0] T_BIN_10NS = 32'h0000_1ddb;
	localparam logic [31:0] NS_PER_UNIT = 32'h0000_000a;
	localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_0014;

	typedef enum logic [2:0] {
		W_IDLE = 3'h1,
		W_GAP = 3'h2,
		W_LINE = 3'h4
	} pxs_wstate_t;

	// Position inside [first, first + count), positions counted from 1
	function automatic logic in_span(input logic [10:0] pos, input logic [10:0] first,
		input logic [10:0] count);
		logic [11:0] stop;
		stop = {1'b0, first} + {1'b0, count};
		in_span = (pos >= first) && ({1'b0, pos} < stop);
	endfunction : in_span
endpackage : pxs_pkg

// File: common/pxs_cfg_if.sv
`timescale 1ns/1ns
interface pxs_cfg_if;
	logic [1:0] mode;
	logic [1:0] shift;
	logic [10:0] first_col;
	logic [10:0] col_cnt;
	logic [10:0] first_line;
	logic [10:0] line_cnt;
	modport ctl (output mode, shift, first_col, col_cnt, first_line, line_cnt);
	modport sink (input mode, shift, first_col, col_cnt, first_line, line_cnt);
endinterface : pxs_cfg_if

// File: verilog/pxs_shift.sv
`timescale 1ns/1ns
module pxs_shift
	import pxs_pkg::*;
(
	// Raw sample
	input wire logic [11:0] adc,
	// Active settings
	pxs_cfg_if.sink cfg,
	// Right-aligned output word
	output logic [11:0] pix
);
	logic [14:0] shifted;
	logic [11:0] dropped;
	logic sat;
	logic [11:0] sel;
	logic [11:0] ones;
	logic [11:0] lsb;

	assign shifted = {3'h0, adc} << cfg.shift;
	assign dropped = ~(ADC_ALL_ONES >> cfg.shift);
	assign sat = |(adc & dropped);
	assign lsb = (cfg.mode == MODE_12) ? 12'(LSB_12) :
		(cfg.mode == MODE_10) ? 12'(LSB_10) : 12'(LSB_8);
	assign sel = shifted[11:0] >> lsb;
	assign ones = ADC_ALL_ONES >> lsb;
	assign pix = sat ? ones : sel;
endmodule : pxs_shift

// File: verilog/pxs_window.sv
`timescale 1ns/1ns
module pxs_window
	import pxs_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// Sensor pixel event and its frame and line levels
	input wire logic pe,
	input wire logic fv,
	input wire logic lv,
	// Settings for this frame
	pxs_cfg_if.sink cfg,
	// Position flags for the pixel of this event
	output logic frame_start,
	output logic line_hit,
	output logic col_hit
);
	pxs_wstate_t state_reg;
	logic [10:0] line_reg;
	logic [10:0] col_reg;
	logic [10:0] cur_line;
	logic [10:0] cur_col;

	assign frame_start = pe && fv && (state_reg == W_IDLE);
	assign cur_line = (state_reg == W_LINE) ? line_reg : POS_W'(line_reg + POS_ONE);
	assign cur_col = (state_reg == W_LINE) ? POS_W'(col_reg + POS_ONE) : POS_ONE;
	// Sums stay in range when software keeps the window inside the sensor
	assign line_hit = in_span(cur_line, cfg.first_line, cfg.line_cnt);
	assign col_hit = in_span(cur_col, cfg.first_col, cfg.col_cnt);

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= W_IDLE;
			line_reg <= 11'h000;
			col_reg <= 11'h000;
		end else if (ce && pe) begin
			case (state_reg)
				W_IDLE, W_GAP: begin
					if (!fv) begin
						state_reg <= W_IDLE;
						line_reg <= 11'h000;
					end else if (lv) begin
						state_reg <= W_LINE;
						line_reg <= cur_line;
						col_reg <= POS_ONE;
					end else begin
						state_reg <= W_GAP;
					end
				end
				W_LINE: begin
					if (!fv) begin
						state_reg <= W_IDLE;
						line_reg <= 11'h000;
					end else if (lv) begin
						col_reg <= cur_col;
					end else begin
						state_reg <= W_GAP;
					end
				end
				default: begin
					state_reg <= W_IDLE;
				end
			endcase
		end
	end
endmodule : pxs_window

// File: verilog/pxs_top.sv
// Contract
// - 8 bit, no shift sends bits 11..4
// - 8 bit, one step sends bits 10..3
// - 8 bit, two steps send bits 9..2
// - 8 bit, three steps send bits 8..1
// - Dropped upper bit set forces all ones
// - Window is first column, columns, first line, lines
// - Only window lines leave the camera
// - Full array window is the reset setting
// - Minimum frame period without vertical binning
// - Minimum frame period with vertical binning
// - 12 bit mode shifts in zeros below
// - 10 bit mode sends bits 11..2 unshifted
// - Pixels outside window columns sent dark, lval low
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module pxs_top
	import pxs_pkg::*;
#(
	parameter logic [31:0] BASE_10NS = T_BASE_10NS,
	parameter logic [31:0] SKIP_10NS = T_SKIP_10NS,
	parameter logic [31:0] LINE_10NS = T_LINE_10NS,
	parameter logic [31:0] BIN_10NS = T_BIN_10NS
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sensor stream, asynchronous to mclk
	input wire logic sen_clk,
	input wire logic sen_fval,
	input wire logic sen_lval,
	input wire logic [11:0] sen_data,
	// Video out
	output logic vid_fval,
	output logic vid_lval,
	output logic vid_strobe,
	output logic [11:0] vid_data
);
	pxs_cfg_if cfg_bus ();

	// Synchronisers; the data bus is stable around the sensor clock edge it is taken on
	logic clk_s1, clk_s2, clk_s3;
	logic fv_s1, fv_s2;
	logic lv_s1, lv_s2;
	logic [11:0] dat_s1, dat_s2;

	// Staged and active settings
	logic [1:0] stg_mode_reg, act_mode_reg;
	logic [1:0] stg_shift_reg, act_shift_reg;
	logic stg_vbin_reg, act_vbin_reg;
	logic [10:0] stg_fcol_reg, act_fcol_reg;
	logic [10:0] stg_ncol_reg, act_ncol_reg;
	logic [10:0] stg_fline_reg, act_fline_reg;
	logic [10:0] stg_nline_reg, act_nline_reg;
	logic pend_reg;

	// Frame timing
	logic [31:0] min_cyc_reg;
	logic [31:0] per_cnt_reg;
	logic seen_reg;
	logic late_reg;
	logic [31:0] frames_reg;

	// APB output flops
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// Video output flops
	logic vid_fval_reg;
	logic vid_lval_reg;
	logic vid_strobe_reg;
	logic [11:0] vid_data_reg;

	// Internal wires
	logic pe;
	logic frame_start;
	logic line_hit;
	logic col_hit;
	logic [11:0] shaped;
	logic send_line;
	logic send_pix;
	logic acc_first;
	logic wr_en;
	logic sel_ctrl, sel_cols, sel_lines, sel_status, sel_min, sel_frames;
	logic mapped;
	logic cfg_wr;
	logic late_clr;
	logic [31:0] rd_word;
	logic [10:0] skip_lines;
	logic [31:0] win_term;
	logic [31:0] total_10ns;
	logic [31:0] min_cyc_next;

	assign pe = clk_s2 && !clk_s3;

	always_ff @(posedge mclk) begin
		if (srst) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			fv_s1 <= 1'b0;
			fv_s2 <= 1'b0;
			lv_s1 <= 1'b0;
			lv_s2 <= 1'b0;
			dat_s1 <= 12'h000;
			dat_s2 <= 12'h000;
		end else if (ce) begin
			clk_s1 <= sen_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			fv_s1 <= sen_fval;
			fv_s2 <= fv_s1;
			lv_s1 <= sen_lval;
			lv_s2 <= lv_s1;
			dat_s1 <= sen_data;
			dat_s2 <= dat_s1;
		end
	end

	// A frame that starts this cycle already sees the staged values
	assign cfg_bus.mode = frame_start ? stg_mode_reg : act_mode_reg;
	assign cfg_bus.shift = frame_start ? stg_shift_reg : act_shift_reg;
	assign cfg_bus.first_col = frame_start ? stg_fcol_reg : act_fcol_reg;
	assign cfg_bus.col_cnt = frame_start ? stg_ncol_reg : act_ncol_reg;
	assign cfg_bus.first_line = frame_start ? stg_fline_reg : act_fline_reg;
	assign cfg_bus.line_cnt = frame_start ? stg_nline_reg : act_nline_reg;

	pxs_window u_window (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.pe(pe),
		.fv(fv_s2),
		.lv(lv_s2),
		.cfg(cfg_bus),
		.frame_start(frame_start),
		.line_hit(line_hit),
		.col_hit(col_hit)
	);

	pxs_shift u_shift (
		.adc(dat_s2),
		.cfg(cfg_bus),
		.pix(shaped)
	);

	// Video path
	assign send_line = fv_s2 && lv_s2 && line_hit;
	assign send_pix = send_line && col_hit;

	always_ff @(posedge mclk) begin
		if (srst) begin
			vid_fval_reg <= 1'b0;
			vid_lval_reg <= 1'b0;
			vid_strobe_reg <= 1'b0;
			vid_data_reg <= 12'h000;
		end else if (ce) begin
			vid_strobe_reg <= pe && send_line;
			if (pe) begin
				vid_fval_reg <= fv_s2;
				vid_lval_reg <= send_pix;
				vid_data_reg <= send_pix ? shaped : 12'h000;
			end
		end
	end

	// APB decode; access lasts two cycles, pready rises in the second
	assign acc_first = psel && penable && !pready_reg;
	assign wr_en = psel && penable && pready_reg && pwrite;
	assign sel_ctrl = (paddr == REG_CTRL);
	assign sel_cols = (paddr == REG_COLS);
	assign sel_lines = (paddr == REG_LINES);
	assign sel_status = (paddr == REG_STATUS);
	assign sel_min = (paddr == REG_MIN_PERIOD);
	assign sel_frames = (paddr == REG_FRAMES);
	assign mapped = sel_ctrl || sel_cols || sel_lines || sel_status || sel_min || sel_frames;
	assign cfg_wr = wr_en && (sel_ctrl || sel_cols || sel_lines);
	assign late_clr = wr_en && sel_status && pwdata[STAT_LATE_BIT];

	assign rd_word = sel_ctrl ? {27'h000_0000, stg_vbin_reg, stg_shift_reg, stg_mode_reg} :
		sel_cols ? {5'h00, stg_ncol_reg, 5'h00, stg_fcol_reg} :
		sel_lines ? {5'h00, stg_nline_reg, 5'h00, stg_fline_reg} :
		sel_status ? {29'h0000_0000, pend_reg, late_reg, vid_fval_reg} :
		sel_min ? min_cyc_reg :
		sel_frames ? frames_reg : 32'h0000_0000;

	always_ff @(posedge mclk) begin
		if (srst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			pready_reg <= acc_first;
			pslverr_reg <= acc_first && !mapped;
			if (acc_first && !pwrite) begin
				prdata_reg <= rd_word;
			end
		end
	end

	// Staged settings; reset gives the full array
	always_ff @(posedge mclk) begin
		if (srst) begin
			stg_mode_reg <= MODE_12;
			stg_shift_reg <= 2'h0;
			stg_vbin_reg <= 1'b0;
			stg_fcol_reg <= RST_FIRST;
			stg_ncol_reg <= SENSOR_COLS;
			stg_fline_reg <= RST_FIRST;
			stg_nline_reg <= SENSOR_LINES;
		end else if (ce && wr_en) begin
			if (sel_ctrl) begin
				stg_mode_reg <= pwdata[CTRL_MODE_LSB +: 2];
				stg_shift_reg <= pwdata[CTRL_SHIFT_LSB +: 2];
				stg_vbin_reg <= pwdata[CTRL_VBIN_BIT];
			end
			if (sel_cols) begin
				stg_fcol_reg <= pwdata[WIN_FIRST_LSB +: POS_W];
				stg_ncol_reg <= pwdata[WIN_COUNT_LSB +: POS_W];
			end
			if (sel_lines) begin
				stg_fline_reg <= pwdata[WIN_FIRST_LSB +: POS_W];
				stg_nline_reg <= pwdata[WIN_COUNT_LSB +: POS_W];
			end
		end
	end

	// Active settings move only when a frame begins
	always_ff @(posedge mclk) begin
		if (srst) begin
			act_mode_reg <= MODE_12;
			act_shift_reg <= 2'h0;
			act_vbin_reg <= 1'b0;
			act_fcol_reg <= RST_FIRST;
			act_ncol_reg <= SENSOR_COLS;
			act_fline_reg <= RST_FIRST;
			act_nline_reg <= SENSOR_LINES;
			pend_reg <= 1'b0;
		end else if (ce) begin
			if (frame_start) begin
				act_mode_reg <= stg_mode_reg;
				act_shift_reg <= stg_shift_reg;
				act_vbin_reg <= stg_vbin_reg;
				act_fcol_reg <= stg_fcol_reg;
				act_ncol_reg <= stg_ncol_reg;
				act_fline_reg <= stg_fline_reg;
				act_nline_reg <= stg_nline_reg;
			end
			// A write in the start cycle stays pending for the next frame
			if (cfg_wr) begin
				pend_reg <= 1'b1;
			end else if (frame_start) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// Minimum frame period for the active height, rounded up to whole cycles
	assign skip_lines = POS_W'(SENSOR_LINES - act_nline_reg);
	assign win_term = act_vbin_reg ?
		32'(({21'h00_0000, act_nline_reg} >> 1) + 32'h0000_0001) * BIN_10NS :
		32'({21'h00_0000, act_nline_reg} + 32'h0000_0001) * LINE_10NS;
	assign total_10ns = 32'(BASE_10NS + {21'h00_0000, skip_lines} * SKIP_10NS + win_term);
	assign min_cyc_next = 32'((total_10ns * NS_PER_UNIT + CLK_PERIOD_NS - 32'h0000_0001) / CLK_PERIOD_NS);

	always_ff @(posedge mclk) begin
		if (srst) begin
			min_cyc_reg <= 32'h0000_0000;
			per_cnt_reg <= 32'h0000_0000;
			seen_reg <= 1'b0;
			late_reg <= 1'b0;
			frames_reg <= 32'h0000_0000;
		end else if (ce) begin
			min_cyc_reg <= min_cyc_next;
			if (frame_start) begin
				per_cnt_reg <= 32'h0000_0001;
				seen_reg <= 1'b1;
				frames_reg <= frames_reg + 32'h0000_0001;
			end else if (per_cnt_reg != 32'hffff_ffff) begin
				per_cnt_reg <= per_cnt_reg + 32'h0000_0001;
			end
			// A frame that comes too soon is flagged; the set wins over a clear
			if (frame_start && seen_reg && (per_cnt_reg < min_cyc_reg)) begin
				late_reg <= 1'b1;
			end else if (late_clr) begin
				late_reg <= 1'b0;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign vid_fval = vid_fval_reg;
	assign vid_lval = vid_lval_reg;
	assign vid_strobe = vid_strobe_reg;
	assign vid_data = vid_data_reg;
endmodule : pxs_top

// File: sim/pxs_top_props.sv
`timescale 1ns/1ns
module pxs_top_props (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sensor stream
	input wire logic sen_clk,
	input wire logic sen_fval,
	input wire logic sen_lval,
	input wire logic [11:0] sen_data,
	// Video out
	input wire logic vid_fval,
	input wire logic vid_lval,
	input wire logic vid_strobe,
	input wire logic [11:0] vid_data
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	reset_quiet_a: assert property ($fell(srst) |-> !vid_fval && !vid_strobe && !pready && !pslverr && !vid_lval)
		else $error("outputs not quiet after reset");
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after first access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_unmapped_a: assert property (pready && paddr > 8'h14 |-> pslverr)
		else $error("unmapped access without pslverr");
	dark_pixel_a: assert property (!vid_lval |-> vid_data == 12'h000)
		else $error("data not zero while lval low");
	lval_start_a: assert property ($rose(vid_lval) |-> vid_strobe)
		else $error("lval rose without a transmitted pixel");
	strobe_space_a: assert property (vid_strobe |=> !vid_strobe [*3])
		else $error("strobes closer than one pixel period");
	frame_bound_a: assert property (!vid_fval |-> !vid_lval && !vid_strobe)
		else $error("pixel sent outside a frame");

	cover property (vid_strobe && vid_lval);
	cover property (vid_strobe && !vid_lval);
	cover property (pready && pslverr);
endmodule : pxs_top_props

// File: sim/pxs_sensor_model.sv
`timescale 1ns/1ns
module pxs_sensor_model (
	// Bench control
	input wire logic go,
	input wire logic [11:0] tab [6],
	output logic done,
	// Sensor stream
	output logic sen_clk,
	output logic sen_fval,
	output logic sen_lval,
	output logic [11:0] sen_data
);
	// Data settles three system clocks before the rise; clock stands still between frames
	task automatic pulse();
		#60 sen_clk = 1'b1;
		#80 sen_clk = 1'b0;
		#20;
	endtask : pulse

	initial begin
		{sen_clk, sen_fval, sen_lval, done} = 4'h0;
		sen_data = 12'h000;
		forever begin
			@(posedge go);
			done = 1'b0;
			// Step off the system clock edges so no pin moves as it is sampled
			#5;
			sen_fval = 1'b1;
			for (int l = 0; l < 4; l++) begin
				sen_lval = 1'b1;
				for (int c = 0; c < 6; c++) begin
					sen_data = tab[c];
					pulse();
				end
				sen_lval = 1'b0;
				// Line gap carries junk so a stale sample is never mistaken for data
				sen_data = ~sen_data;
				pulse();
				pulse();
			end
			sen_fval = 1'b0;
			pulse();
			done = 1'b1;
		end
	end
endmodule : pxs_sensor_model

// File: sim/tb_pixel_shift_and_aoi_window.sv
`timescale 1ns/1ns
module tb_pixel_shift_and_aoi_window
	import pxs_pkg::*;
;
	logic mclk, srst, ce, psel, penable, pwrite, pready, pslverr, go, done, err;
	logic sen_clk, sen_fval, sen_lval, vid_fval, vid_lval, vid_strobe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] sen_data, vid_data;
	// Window columns mix a dim sample with bright ones that break the shift limits
	logic [11:0] tab [6] = '{12'hfff, 12'h0ab, 12'h5a5, 12'h8f0, 12'h7ff, 12'hfff};
	// The last entry is the spare mode code, which must act as 8 bit
	logic [4:0] ctab [11] = '{5'h02, 5'h06, 5'h0a, 5'h0e, 5'h04, 5'h0c, 5'h01, 5'h09, 5'h0d, 5'h10, 5'h03};
	logic [4:0] cur;
	int mismatches, check_count, k, cyc;

	// Short frame timing terms: 100, 10, 50, 60 units of 10 ns
	pxs_top #(.BASE_10NS(32'h0000_0064), .SKIP_10NS(32'h0000_000a), .LINE_10NS(32'h0000_0032),
		.BIN_10NS(32'h0000_003c)) dut (.mclk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sen_clk, .sen_fval, .sen_lval, .sen_data, .vid_fval, .vid_lval,
		.vid_strobe, .vid_data);
	pxs_sensor_model model (.go, .tab, .done, .sen_clk, .sen_fval, .sen_lval, .sen_data);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Hold the request until pready is seen high at a rising edge, take the answer at that edge
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Shift in zeros, saturate when a dropped top bit is set, then right-align to the mode width
	function automatic logic [11:0] shape(input logic [4:0] c, input logic [11:0] a);
		logic [11:0] w;
		w = a << c[3:2];
		if ((a >> (4'hc - c[3:2])) != 12'h000)
			w = ADC_ALL_ONES;
		shape = c[1:0] == MODE_12 ? w : c[1:0] == MODE_10 ? w >> LSB_10 : w >> LSB_8;
	endfunction : shape

	always @(negedge mclk) begin
		if (vid_strobe === 1'b1) begin
			check("lval", vid_lval, k % 6 inside {[1:3]});
			check("pixel", vid_data, (k % 6 inside {[1:3]}) ? shape(cur, tab[k % 6]) : 12'h000);
			k++;
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		{srst, ce, psel, penable, pwrite, go} = 6'h30;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		apb(0, REG_CTRL, 0);
		check("ctrl", rd, 32'h0000_0000);
		apb(0, REG_COLS, 0);
		check("cols", rd, 32'h0570_0001);
		apb(0, REG_LINES, 0);
		check("lines", rd, 32'h0410_0001);
		apb(0, REG_MIN_PERIOD, 0);
		check("period", rd, 32'h0000_65db);
		apb(0, 8'h20, 0);
		check("slverr", err, 1'b1);
		check("unmapped", rd, 32'h0000_0000);
		// Window kept inside the sensor: columns 2..4, lines 2..3
		apb(1, REG_COLS, 32'h0003_0002);
		apb(1, REG_LINES, 32'h0002_0002);
		apb(1, REG_CTRL, {27'h000_0000, ctab[0]});
		for (int i = 0; i < 11; i++) begin
			cur = ctab[i];
			k = 0;
			go <= 1'b1;
			@(posedge mclk);
			go <= 1'b0;
			while (vid_fval !== 1'b1) @(posedge mclk);
			apb(0, REG_MIN_PERIOD, 0);
			check("period", rd, cur[4] ? 32'h0000_14b4 : 32'h0000_14c3);
			// Next setting lands mid-frame and must wait for the next frame
			if (i < 10) begin
				apb(1, REG_CTRL, {27'h000_0000, ctab[i + 1]});
				apb(0, REG_STATUS, 0);
				check("pending", {rd[2], rd[0]}, 2'b11);
			end
			while (done !== 1'b1) @(posedge mclk);
			check("strobes", k, 12);
		end
		// A frozen block must miss a whole frame and count nothing
		ce <= 1'b0;
		k = 0;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		while (done !== 1'b1) @(posedge mclk);
		ce <= 1'b1;
		check("frozen", k, 0);
		apb(0, REG_STATUS, 0);
		check("late", rd[1], 1'b1);
		apb(1, REG_STATUS, 32'h0000_0002);
		apb(0, REG_STATUS, 0);
		check("status", rd, 32'h0000_0000);
		apb(0, REG_FRAMES, 0);
		check("frames", rd, 32'h0000_000b);
		give_verdict();
	end
endmodule : tb_pixel_shift_and_aoi_window

bind pxs_top pxs_top_props props (.mclk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .sen_clk, .sen_fval, .sen_lval, .sen_data, .vid_fval, .vid_lval, .vid_strobe, .vid_data);
